/* inc/frc_pkg.sv */
// Purpose: Shared constants for the clearing and start-up configuration link
// Assumes: Both ends run on pclk at 10 MHz
// Notes: Size codes, offset presets, divider and host register map below
package frc_pkg;
    localparam int DATA_W = 36;
    localparam int BYTE_W = 9;
    localparam int HALF_W = 18;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W:0] DEPTH = 9'h100;
    // Bus sizes of the read port
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_BYTE = 2'h2;
    localparam logic [1:0] PIECES_LONG = 2'h0;
    localparam logic [1:0] PIECES_HALF = 2'h1;
    localparam logic [1:0] PIECES_BYTE = 2'h3;
    // Offset presets
    localparam logic [ADDR_W-1:0] OFFSET_64 = 8'h40;
    localparam logic [ADDR_W-1:0] OFFSET_16 = 8'h10;
    localparam logic [ADDR_W-1:0] OFFSET_8 = 8'h08;
    localparam logic [ADDR_W-1:0] OFFSET_DEFAULT = 8'h08;
    // Write edges after clear before space is shown
    localparam logic [1:0] READY_EDGES = 2'h2;
    // Host link clock divider, 8 pclk per period
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] DIV_FALL = 3'h7;
    // Host register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WDATA = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int CTRL_W = 9;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h007;
    localparam int CB_MAIN = 0;
    localparam int CB_SECOND = 1;
    localparam int CB_PARTIAL = 2;
    localparam int CB_TIMING = 3;
    localparam int CB_SEL0 = 4;
    localparam int CB_SEL1 = 5;
    localparam int CB_SERIAL = 6;
    localparam int CB_SIZE = 7;
    localparam int CMD_READ = 0;
endpackage

/* inc/frc_link_if.sv */
`timescale 1ns/100ps
// Purpose: Pin-level link between the FIFO and its controller
// Assumes: Controller makes both port clocks
// Notes: All signals plain wires, no tristate
interface frc_link_if;
    logic write_side_clock;
    logic read_side_clock;
    logic main_clear_n;
    logic second_clear_n;
    logic partial_clear_n;
    logic endian_timing_sel;
    logic offset_sel0;
    logic offset_sel1;
    logic serial_load_mode;
    logic [1:0] bus_size;
    logic wr_en;
    logic [frc_pkg::DATA_W-1:0] wr_data;
    logic rd_en;
    logic [frc_pkg::DATA_W-1:0] rd_data;
    logic space_flag;
    logic empty_flag;
    logic near_empty_n;
    logic near_full_n;
    logic mail1_full;
    logic mail2_full;

    modport dev (
        input write_side_clock, read_side_clock, main_clear_n, second_clear_n,
        input partial_clear_n, endian_timing_sel, offset_sel0, offset_sel1,
        input serial_load_mode, bus_size, wr_en, wr_data, rd_en,
        output rd_data, space_flag, empty_flag, near_empty_n, near_full_n,
        output mail1_full, mail2_full
    );
    modport host (
        output write_side_clock, read_side_clock, main_clear_n, second_clear_n,
        output partial_clear_n, endian_timing_sel, offset_sel0, offset_sel1,
        output serial_load_mode, bus_size, wr_en, wr_data, rd_en,
        input rd_data, space_flag, empty_flag, near_empty_n, near_full_n,
        input mail1_full, mail2_full
    );
endinterface

/* rtl/frc_fifo_dev.sv */
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
// Purpose: FIFO end: clears, start-up straps, timing modes, read port order
// Assumes: All link pins asynchronous to pclk; port clocks far slower
// Notes: Port clocks are sampled, their rising edges found on pclk
module frc_fifo_dev (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    frc_link_if.dev link
);
    localparam int SYNC_W = 13 + frc_pkg::DATA_W;

    typedef enum logic [1:0] {ST_CLEAR, ST_WAIT, ST_RUN} frc_state_e;

    logic [SYNC_W-1:0] sync_a, sync_b;
    logic wclk_s, rclk_s, mclr_s, sclr_s, pclr_s, ets_s, fs0_s, fs1_s, spm_s, wr_en_s, rd_en_s;
    logic [1:0] size_s;
    logic [frc_pkg::DATA_W-1:0] wdat_s;
    logic wclk_q, rclk_q, mclr_q, wedge, redge, mrise, in_clear;
    frc_state_e st;
    logic [1:0] rdy_cnt;
    logic high_first, fall_through, mode_pend;
    logic [frc_pkg::ADDR_W-1:0] offset, next_offset, wp, rp;
    logic [frc_pkg::DATA_W-1:0] mem [frc_pkg::DEPTH];
    logic [frc_pkg::ADDR_W:0] count;
    logic [frc_pkg::DATA_W-1:0] cur, rd_data;
    logic [1:0] idx, last_idx;
    logic have, last, push, pop, step, drop, full, mail1, mail2;

    // Byte order applies to half and byte widths only
    function automatic logic [frc_pkg::DATA_W-1:0] piece(
        input logic [frc_pkg::DATA_W-1:0] w, input logic [1:0] i,
        input logic [1:0] sz, input logic hb);
        logic [1:0] pos;
        logic [frc_pkg::DATA_W-1:0] r;
        pos = 2'h0;
        r = w;
        if (sz == frc_pkg::SIZE_BYTE)
        begin
            pos = hb ? 2'(frc_pkg::PIECES_BYTE - i) : i;
            r = frc_pkg::DATA_W'(w[32'(pos) * frc_pkg::BYTE_W +: frc_pkg::BYTE_W]);
        end
        else if (sz == frc_pkg::SIZE_HALF)
        begin
            pos = hb ? 2'(frc_pkg::PIECES_HALF - i) : i;
            r = frc_pkg::DATA_W'(w[32'(pos) * frc_pkg::HALF_W +: frc_pkg::HALF_W]);
        end
        return r;
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= '0;
            sync_b <= '0;
            wclk_q <= 1'b0;
            rclk_q <= 1'b0;
            mclr_q <= 1'b0;
        end
        else
        begin
            sync_a <= {link.write_side_clock, link.read_side_clock, link.main_clear_n,
                       link.second_clear_n, link.partial_clear_n, link.endian_timing_sel,
                       link.offset_sel0, link.offset_sel1, link.serial_load_mode,
                       link.wr_en, link.rd_en, link.bus_size, link.wr_data};
            sync_b <= sync_a;
            wclk_q <= wclk_s;
            rclk_q <= rclk_s;
            mclr_q <= mclr_s;
        end
    end

    assign {wclk_s, rclk_s, mclr_s, sclr_s, pclr_s, ets_s, fs0_s, fs1_s, spm_s,
            wr_en_s, rd_en_s, size_s, wdat_s} = sync_b;

    assign wedge = wclk_s & ~wclk_q;
    assign redge = rclk_s & ~rclk_q;
    assign mrise = mclr_s & ~mclr_q;
    assign in_clear = ~mclr_s | ~sclr_s | ~pclr_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= ST_CLEAR;
            rdy_cnt <= 2'h0;
        end
        else if (in_clear)
        begin
            st <= ST_CLEAR;
            rdy_cnt <= 2'h0;
        end
        else
        begin
            case (st)
                ST_CLEAR:
                    st <= ST_WAIT;
                ST_WAIT:
                begin
                    if (wedge)
                    begin
                        rdy_cnt <= 2'(rdy_cnt + 2'h1);
                        if (rdy_cnt == 2'(frc_pkg::READY_EDGES - 2'h1))
                            st <= ST_RUN;
                    end
                end
                ST_RUN:
                    st <= ST_RUN;
                default:
                    st <= ST_CLEAR;
            endcase
        end
    end

    // Straps move only on main clear; partial clear leaves them alone
    // settings kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_first <= 1'b0;
            offset <= frc_pkg::OFFSET_DEFAULT;
            fall_through <= 1'b0;
            mode_pend <= 1'b0;
        end
        else if (mrise)
        begin
            high_first <= ets_s;
            offset <= next_offset;
            mode_pend <= 1'b1;
        end
        else if (mode_pend && mclr_s && wedge)
        begin
            fall_through <= ~ets_s;
            mode_pend <= 1'b0;
        end
    end

    assign next_offset = !spm_s ? frc_pkg::OFFSET_DEFAULT :
                         (fs0_s && fs1_s) ? frc_pkg::OFFSET_64 :
                         fs1_s ? frc_pkg::OFFSET_16 :
                         fs0_s ? frc_pkg::OFFSET_8 : frc_pkg::OFFSET_DEFAULT;

    assign full = (count == frc_pkg::DEPTH);
    assign last_idx = (size_s == frc_pkg::SIZE_BYTE) ? frc_pkg::PIECES_BYTE :
                      (size_s == frc_pkg::SIZE_HALF) ? frc_pkg::PIECES_HALF :
                      frc_pkg::PIECES_LONG;
    assign last = (idx == last_idx);
    assign push = (st == ST_RUN) & ~in_clear & wedge & wr_en_s & ~full;
    assign pop = redge & ~in_clear & (count != '0) &
                 (fall_through ? (~have | (rd_en_s & last)) : (rd_en_s & (~have | last)));
    assign step = redge & ~in_clear & rd_en_s & have & ~last;
    assign drop = redge & ~in_clear & rd_en_s & have & last & ~pop;

    always_ff @(posedge pclk)
    begin
        if (push)
            mem[wp] <= wdat_s;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end
        else if (in_clear)
        begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wp <= frc_pkg::ADDR_W'(wp + 1'b1);
            if (pop)
                rp <= frc_pkg::ADDR_W'(rp + 1'b1);
            if (push && !pop)
                count <= (frc_pkg::ADDR_W + 1)'(count + 1'b1);
            else if (pop && !push)
                count <= (frc_pkg::ADDR_W + 1)'(count - 1'b1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            have <= 1'b0;
            idx <= 2'h0;
            cur <= '0;
            rd_data <= '0;
        end
        else if (in_clear)
        begin
            have <= 1'b0;
            idx <= 2'h0;
            cur <= '0;
            rd_data <= '0;
        end
        else if (pop)
        begin
            have <= 1'b1;
            idx <= 2'h0;
            cur <= mem[rp];
            rd_data <= piece(mem[rp], 2'h0, size_s, high_first);
        end
        else if (step)
        begin
            idx <= 2'(idx + 2'h1);
            rd_data <= piece(cur, 2'(idx + 2'h1), size_s, high_first);
        end
        else if (drop)
            have <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mail1 <= 1'b1;
            mail2 <= 1'b1;
        end
        else
        begin
            if (!mclr_s || !pclr_s)
                mail1 <= 1'b1;
            if (!sclr_s || !pclr_s)
                mail2 <= 1'b1;
        end
    end

    assign link.space_flag = (st == ST_RUN) & ~in_clear & ~full;
    assign link.empty_flag = ~in_clear &
                             (fall_through ? have : ((count != '0) | (have & ~last)));
    assign link.near_empty_n = ~in_clear & (count > {1'b0, offset});
    assign link.near_full_n = in_clear |
                              ((frc_pkg::ADDR_W + 1)'(frc_pkg::DEPTH - count) > {1'b0, offset});
    assign link.rd_data = rd_data;
    assign link.mail1_full = mail1;
    assign link.mail2_full = mail2;
endmodule

/* rtl/frc_fifo_host.sv */
`timescale 1ns/100ps
// Purpose: Controller end: APB registers driving clears, straps, writes, reads
// Assumes: Software follows the flag bits before issuing words
// Notes: Link clocks are pclk divided by eight; enables and write data change on falling edges
module frc_fifo_host (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    frc_link_if.host link
);
    localparam int SYNC_W = 6 + frc_pkg::DATA_W;

    logic [SYNC_W-1:0] sync_a, sync_b;
    logic space_s, empty_s, ne_s, nf_s, m1_s, m2_s;
    logic [frc_pkg::DATA_W-1:0] rdat_s;
    logic [frc_pkg::CTRL_W-1:0] ctrl;
    logic [frc_pkg::DIV_W-1:0] div;
    logic fall, mapped, wr_acc, wr_pend, wr_en, rd_pend, rd_en, wr_go, rd_go;
    logic [frc_pkg::DATA_W-1:0] wdata, out_data;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= {link.space_flag, link.empty_flag, link.near_empty_n,
                       link.near_full_n, link.mail1_full, link.mail2_full, link.rd_data};
            sync_b <= sync_a;
        end
    end
    assign {space_s, empty_s, ne_s, nf_s, m1_s, m2_s, rdat_s} = sync_b;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div <= '0;
        end
        else
        begin
            div <= frc_pkg::DIV_W'(div + 1'b1);
        end
    end
    assign fall = (div == frc_pkg::DIV_FALL);

    assign mapped = (paddr == frc_pkg::REG_CTRL) | (paddr == frc_pkg::REG_WDATA) |
                    (paddr == frc_pkg::REG_CMD) | (paddr == frc_pkg::REG_STATUS) |
                    (paddr == frc_pkg::REG_RDATA);
    assign wr_acc = psel & penable & pwrite & mapped;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Read data latched in setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                frc_pkg::REG_CTRL: prdata <= 32'(ctrl);
                frc_pkg::REG_WDATA: prdata <= wdata[31:0];
                frc_pkg::REG_STATUS: prdata <= {24'h0, rd_pend | rd_en, wr_pend | wr_en,
                                                m2_s, m1_s, nf_s, ne_s, empty_s, space_s};
                frc_pkg::REG_RDATA: prdata <= rdat_s[31:0];
                default: prdata <= '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= frc_pkg::CTRL_RESET;
        end
        else if (wr_acc && paddr == frc_pkg::REG_CTRL)
        begin
            ctrl <= pwdata[frc_pkg::CTRL_W-1:0];
        end
    end

    // Only one transfer per two link periods: the flag has settled by then
    assign wr_go = fall & ~wr_en & ~rd_en & wr_pend & space_s;
    assign rd_go = fall & ~wr_en & ~rd_en & ~wr_go & rd_pend & empty_s;

    // New request wins over the launch that clears the old one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wdata <= '0;
        end
        else
        begin
            if (wr_acc && paddr == frc_pkg::REG_WDATA)
            begin
                wr_pend <= 1'b1;
                wdata <= frc_pkg::DATA_W'(pwdata);
            end
            else if (wr_go)
            begin
                wr_pend <= 1'b0;
            end
            if (wr_acc && paddr == frc_pkg::REG_CMD && pwdata[frc_pkg::CMD_READ])
            begin
                rd_pend <= 1'b1;
            end
            else if (rd_go)
            begin
                rd_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_en <= 1'b0;
            rd_en <= 1'b0;
            out_data <= '0;
        end
        else if (fall)
        begin
            wr_en <= wr_go;
            rd_en <= rd_go;
            if (wr_go)
            begin
                out_data <= wdata;
            end
        end
    end

    assign link.write_side_clock = div[frc_pkg::DIV_W-1];
    assign link.read_side_clock = div[frc_pkg::DIV_W-1];
    assign link.main_clear_n = ~ctrl[frc_pkg::CB_MAIN];
    assign link.second_clear_n = ~ctrl[frc_pkg::CB_SECOND];
    assign link.partial_clear_n = ~ctrl[frc_pkg::CB_PARTIAL];
    assign link.endian_timing_sel = ctrl[frc_pkg::CB_TIMING];
    assign link.offset_sel0 = ctrl[frc_pkg::CB_SEL0];
    assign link.offset_sel1 = ctrl[frc_pkg::CB_SEL1];
    assign link.serial_load_mode = ctrl[frc_pkg::CB_SERIAL];
    assign link.bus_size = ctrl[frc_pkg::CB_SIZE +: 2];
    assign link.wr_en = wr_en;
    assign link.wr_data = out_data;
    assign link.rd_en = rd_en;
endmodule

/* verification/frc_link_monitor.sv */
// Purpose: Link checker for clears, flags and standard-mode read timing
// Assumes: One pclk domain; port clocks sampled on it
// Notes: Timing mode is tracked from the link pins
`timescale 1ns/100ps
module frc_link_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host side pins
    input wire logic write_side_clock,
    input wire logic main_clear_n,
    input wire logic second_clear_n,
    input wire logic partial_clear_n,
    input wire logic endian_timing_sel,
    input wire logic rd_en,
    // Device side pins
    input wire logic [frc_pkg::DATA_W-1:0] rd_data,
    input wire logic space_flag,
    input wire logic empty_flag,
    input wire logic near_empty_n,
    input wire logic near_full_n,
    input wire logic mail1_full,
    input wire logic mail2_full
);
    logic clr_q, wclk_q, armed, std_mode;
    logic [7:0] run, since_rd;
    wire clr_all = main_clear_n & second_clear_n & partial_clear_n;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Mode is unknown until the first write edge after main clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {clr_q, wclk_q, armed, std_mode} <= 4'h3;
            run <= 8'h00;
            since_rd <= 8'hff;
        end
        else
        begin
            clr_q <= clr_all;
            wclk_q <= write_side_clock;
            run <= (clr_all != clr_q) ? 8'h00 : run + 8'(run != 8'hff);
            since_rd <= rd_en ? 8'h00 : since_rd + 8'(since_rd != 8'hff);
            if (!main_clear_n)
                armed <= 1'b1;
            else if (armed && write_side_clock && !wclk_q)
            begin
                armed <= 1'b0;
                std_mode <= endian_timing_sel;
            end
        end
    end
    clear_flags_a: assert property ((!clr_all)[*5] |-> // flags held
        !space_flag && !empty_flag && !near_empty_n && near_full_n)
        else $error("Flags left reset state during clear");
    mail1_force_a: assert property ((!main_clear_n)[*5] |-> mail1_full) // first mail
        else $error("Mail flag one not forced");
    mail2_force_a: assert property ((!second_clear_n)[*5] |-> mail2_full) // second mail
        else $error("Mail flag two not forced");
    partial_mail_a: assert property ((!partial_clear_n)[*5] |-> // both mails
        mail1_full && mail2_full) else $error("Partial clear left a mail flag low");
    clear_hold_a: assert property ($rose(clr_all) |-> run >= 8'h1e) // hold
        else $error("Clear released too early");
    space_early_a: assert property ($rose(space_flag) |-> run >= 8'h08) // wait
        else $error("Space shown too soon after clear");
    space_late_a: assert property ($rose(clr_all) |-> // space rises
        ##[8:40] (space_flag || !clr_all)) else $error("Space not shown after clear");
    std_read_a: assert property (std_mode && !armed && clr_all && run > 8'h04 && // reads
        $changed(rd_data) |-> since_rd < 8'h08) else $error("Output changed without a read");
endmodule

/* verification/testbench.sv */
// Purpose: Self-checking bench joining both link ends
// Assumes: Host answers APB without wait states
// Notes: Random words in every size, order and timing mode
`timescale 1ns/100ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    frc_link_if link ();
    frc_fifo_host u_frc_fifo_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
    frc_fifo_dev u_frc_fifo_dev (.pclk(pclk), .presetn(presetn), .link(link.dev));
    frc_link_monitor u_frc_link_monitor (.pclk(pclk), .presetn(presetn),
        .write_side_clock(link.write_side_clock), .main_clear_n(link.main_clear_n),
        .second_clear_n(link.second_clear_n), .partial_clear_n(link.partial_clear_n),
        .endian_timing_sel(link.endian_timing_sel), .rd_en(link.rd_en),
        .rd_data(link.rd_data), .space_flag(link.space_flag), .empty_flag(link.empty_flag),
        .near_empty_n(link.near_empty_n), .near_full_n(link.near_full_n),
        .mail1_full(link.mail1_full), .mail2_full(link.mail2_full));
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic poll(input logic [7:0] mask, input logic [7:0] val);
        repeat (4) @(posedge pclk);
        for (int t = 0; t < 200; t++)
        begin
            apb(1'b0, frc_pkg::REG_STATUS, 32'h0);
            if ((rv[7:0] & mask) === val)
                break;
        end
        chk("status", 32'(rv[7:0] & mask), 32'(val)); // status reached
    endtask
    task automatic clear(input logic [8:0] cfg, input logic [2:0] which);
        apb(1'b1, frc_pkg::REG_CTRL, 32'({cfg[8:3], which}));
        repeat (40) @(posedge pclk);
        apb(1'b0, frc_pkg::REG_STATUS, 32'h0);
        chk("clear flags", 32'(rv[5:0]), 32'h38); // flags forced
        apb(1'b1, frc_pkg::REG_CTRL, 32'({cfg[8:3], 3'h0}));
        poll(8'h01, 8'h01);
    endtask
    task automatic rd_cmd();
        apb(1'b1, frc_pkg::REG_CMD, 32'h1);
        poll(8'h80, 8'h00);
    endtask
    function automatic logic [31:0] piece(input logic [35:0] w, input int i, input int sz,
        input logic hb);
        int k;
        k = hb ? 3 - i : i;
        if (sz == 0)
            return w[31:0];
        if (sz == 1)
            return 32'((hb ^ (i == 1)) ? w[35:18] : w[17:0]);
        return 32'(w[9*k +: 9]);
    endfunction
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    initial
    begin
        logic [35:0] w;
        logic [8:0] cfg;
        logic sel;
        int sz;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        void'($urandom(58));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, frc_pkg::REG_CTRL, 32'h0);
        chk("ctrl reset", rv, 32'h7); // clears held from reset
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", {31'h0, er}, 32'h1);
        // Last pass is a partial clear that must keep the fall through mode
        for (int k = 0; k < 7; k++)
        begin
            sel = (k == 6) ? 1'b0 : !k[0];
            sz = (k == 6) ? 2 : k / 2;
            cfg = {2'(sz), 3'($urandom), sel, 3'h0};
            clear(cfg, (k == 6) ? 3'h4 : 3'h3);
            w = {4'h0, $urandom};
            apb(1'b1, frc_pkg::REG_WDATA, w[31:0]);
            poll(8'h4e, 8'h0a);
            if (sel)
            begin
                apb(1'b0, frc_pkg::REG_RDATA, 32'h0);
                chk("unread output", rv, 32'h0); // nothing before a read
            end
            for (int i = 0; i < (sz == 0 ? 1 : sz * 2); i++)
            begin
                if (sel)
                    rd_cmd();
                apb(1'b0, frc_pkg::REG_RDATA, 32'h0);
                chk("read piece", rv, piece(w, i, sz, sel)); // order
                if (!sel)
                    rd_cmd();
            end
        end
        // Preset of 16 must outlast a partial clear showing other selects
        clear(9'h068, 3'h3);
        clear(9'h008, 3'h4);
        for (int i = 1; i <= 17; i++)
        begin
            apb(1'b1, frc_pkg::REG_WDATA, $urandom);
            poll(8'h40, 8'h00);
            apb(1'b0, frc_pkg::REG_STATUS, 32'h0);
            if (i >= 16)
                chk("near empty", 32'(rv[2]), 32'(i == 17)); // offset kept
        end
        report_and_stop();
    end
endmodule
